// File: rtl/child_slot_solver.sv
// Solves the hop-duration relation for the child slot size.
`timescale 1ns/1ps
module child_slot_solver
	import hop_sizing_pkg::*;
(
	input wire logic [17:0] hop_duration_us,
	input wire logic [3:0] slot_count,
	input wire logic [6:0] base_slot_size,
	output logic [6:0] child_slot_size
);

	logic [17:0] base_part;
	logic [17:0] per_slot;
	logic [17:0] raw;

	always_comb begin
		base_part = HOP_PER_BYTE * 18'(base_slot_size) + HOP_FIXED;
		per_slot = 18'd0;
		raw = 18'd0;
		// Short hops leave no room; the child size then reads zero.
		if (hop_duration_us > base_part && slot_count != 4'd0) begin
			per_slot = (hop_duration_us - base_part) / 18'(slot_count);
			if (per_slot > HOP_SLOT_OVH) begin
				raw = (per_slot - HOP_SLOT_OVH) / HOP_PER_BYTE;
			end
		end
		if (raw > 18'(CHILD_MAX)) begin
			child_slot_size = CHILD_MAX;
		end else begin
			child_slot_size = raw[6:0];
		end
	end

endmodule

// File: rtl/hop_sizing_pkg.sv
// Constants, types and helper functions for the hop slot sizing block.
//
// Contract
// - With one slot the base slot payload is capped at 105 bytes.
// - Each slot beyond the first lowers that cap by three bytes.
// - Base transmit buffer is base slot size plus nine, at most 114.
// - Each buffered message costs nine header bytes plus its payload.
// - Messages sent per hop never exceed the messages-per-hop limit.
// - A protocol message goes out whole; slots must hold the longest.
// - Child slot size is common, at most 109; buffer nine more, max 118.
// - Child slot size is computed locally, never configured directly.
// - Hop duration equals slots*(80*child+2440)+80*base+3280 microseconds.
// - Hop duration is rounded up to a whole multiple of 500 us.
// - Reset gives base 40 bytes, three slots, 20 ms, child 25 bytes.
// - Slot count limits children per hop; message limit is per node.
// - Only the base configures slot count; others adopt the base value.
// - Slot counts from one up to eight are accepted.
// - Base keeps a remote's slot reserved for gaps below the lease.
// - Grouped messages are protocol messages, all held before sending.
// - Messages-per-hop limit resets to eight.
package hop_sizing_pkg;

	localparam logic [6:0] SLOT_MAX_ONE = 7'd105;
	localparam logic [6:0] SLOT_STEP = 7'd3;
	localparam logic [6:0] HDR_BYTES = 7'd9;
	localparam logic [6:0] BASE_BUF_MAX = 7'd114;
	localparam logic [6:0] CHILD_MAX = 7'd109;
	localparam logic [6:0] CHILD_BUF_MAX = 7'd118;
	localparam logic [3:0] SLOTS_MIN = 4'd1;
	localparam logic [3:0] SLOTS_MAX = 4'd8;
	localparam logic [17:0] HOP_PER_BYTE = 18'd80;
	localparam logic [17:0] HOP_SLOT_OVH = 18'd2440;
	localparam logic [17:0] HOP_FIXED = 18'd3280;
	localparam logic [17:0] HOP_STEP_US = 18'd500;
	localparam int RST_HOP_MS = 20;
	localparam logic [17:0] RST_HOP_US = 18'(RST_HOP_MS * 1000);
	localparam logic [6:0] RST_BASE_SLOT = 7'd40;
	localparam logic [3:0] RST_SLOTS = 4'd3;
	localparam logic [6:0] RST_CHILD_SLOT = 7'd25;
	localparam logic [7:0] RST_MPH = 8'd8;
	localparam logic [7:0] RST_LEASE = 8'd4;

	localparam logic [7:0] OFS_BASE_SLOT = 8'h00;
	localparam logic [7:0] OFS_SLOT_COUNT = 8'h04;
	localparam logic [7:0] OFS_HOP_DUR = 8'h08;
	localparam logic [7:0] OFS_MSG_LIMIT = 8'h0C;
	localparam logic [7:0] OFS_LEASE = 8'h10;
	localparam logic [7:0] OFS_NODE_MODE = 8'h14;
	localparam logic [7:0] OFS_CHILD_SLOT = 8'h18;
	localparam logic [7:0] OFS_BUF_STAT = 8'h1C;
	localparam logic [7:0] OFS_RESERVED = 8'h20;
	localparam logic [7:0] OFS_REQ_HD = 8'h24;

	typedef struct packed {
		logic [7:0] addr;
		logic [31:0] wdata;
		logic we;
		logic re;
	} reg_req_type;

	typedef struct packed {
		logic valid;
		logic protocol;
		logic [6:0] len;
	} msg_req_type;

	typedef struct packed {
		logic valid;
		logic [2:0] id;
	} child_req_type;

	// Largest base slot allowed for a given slot count.
	function automatic logic [6:0] base_slot_cap(input logic [3:0] slots);
		base_slot_cap = SLOT_MAX_ONE
				- 7'(SLOT_STEP * 7'(slots - SLOTS_MIN));
	endfunction

	// Rounds a hop duration up to the next step boundary.
	function automatic logic [17:0] hop_round(input logic [17:0] dur);
		hop_round = 18'(((dur + HOP_STEP_US - 18'd1) / HOP_STEP_US)
				* HOP_STEP_US);
	endfunction

	// Hop duration for a slot count, base size and child size.
	function automatic logic [17:0] hop_formula(input logic [3:0] slots,
			input logic [6:0] base, input logic [6:0] child);
		hop_formula = 18'(slots)
				* (HOP_PER_BYTE * 18'(child) + HOP_SLOT_OVH)
				+ HOP_PER_BYTE * 18'(base) + HOP_FIXED;
	endfunction

endpackage

// File: rtl/hop_slot_sizing.sv
// Per-hop slot sizing, transmit buffer admission and slot lease tracking.
//
// Our own choices: the address-and-strobe port and the register offsets.
`timescale 1ns/1ps
module hop_slot_sizing
	import hop_sizing_pkg::*;
(
	input wire logic core_clk,
	input wire logic sys_rst,
	input wire reg_req_type reg_req,
	output logic [31:0] reg_rdata,
	input wire logic hop_tick,
	input wire logic tx_start,
	input wire msg_req_type msg_req,
	output logic msg_ready,
	input wire logic beacon_valid,
	input wire logic [3:0] beacon_slot_count,
	output logic [3:0] dist_slot_count,
	input wire child_req_type child_req,
	output logic child_grant,
	output logic [6:0] child_slot_size,
	output logic [6:0] tx_buffer_size
);

	typedef struct packed {
		logic is_base;
		logic [6:0] base_slot;
		logic [3:0] slots;
		logic [17:0] hop_us;
		logic [7:0] mph;
		logic [7:0] lease;
		logic [6:0] child_slot;
		logic [7:0] used;
		logic [7:0] count;
		logic tx_open;
		logic [7:0] reserved;
		logic [7:0][7:0] left;
		logic [31:0] rdata;
		logic [3:0] dist_slots;
		logic [6:0] buf_size;
	} state_type;

	state_type cur;
	state_type next_cur;
	logic [6:0] solved_child;
	logic [6:0] slot_limit;
	logic [7:0] cap;
	logic [7:0] need;
	logic [3:0] reserved_count;
	logic [3:0] w_slots;
	logic [6:0] w_base;
	logic [17:0] w_hop;

	child_slot_solver solver (
		.hop_duration_us(cur.hop_us),
		.slot_count(cur.slots),
		.base_slot_size(cur.base_slot),
		.child_slot_size(solved_child)
	);

	// Counts the slots currently held by leases.
	function automatic logic [3:0] ones(input logic [7:0] v);
		ones = 4'd0;
		for (int i = 0; i < 8; i++) begin
			ones = ones + 4'(v[i]);
		end
	endfunction

	// Clamps a slot count into the accepted range.
	function automatic logic [3:0] slots_clamp(input logic [31:0] v);
		if (v < 32'(SLOTS_MIN)) begin
			slots_clamp = SLOTS_MIN;
		end else if (v > 32'(SLOTS_MAX)) begin
			slots_clamp = SLOTS_MAX;
		end else begin
			slots_clamp = v[3:0];
		end
	endfunction

	// Limits a base slot request to what the slot count allows.
	function automatic logic [6:0] base_clamp(input logic [31:0] v,
			input logic [3:0] slots);
		if (v > 32'(base_slot_cap(slots))) begin
			base_clamp = base_slot_cap(slots);
		end else begin
			base_clamp = v[6:0];
		end
	endfunction

	// Transmit buffer for a role: its slot plus one header, capped.
	// The same function feeds admission and the registered size, so the
	// size shown never lags the room that admission really uses.
	function automatic logic [7:0] buf_cap(input logic base,
			input logic [6:0] base_slot, input logic [6:0] child_slot);
		if (base) begin
			buf_cap = 8'(base_slot) + 8'(HDR_BYTES);
			if (buf_cap > 8'(BASE_BUF_MAX)) begin
				buf_cap = 8'(BASE_BUF_MAX);
			end
		end else begin
			buf_cap = 8'(child_slot) + 8'(HDR_BYTES);
			if (buf_cap > 8'(CHILD_BUF_MAX)) begin
				buf_cap = 8'(CHILD_BUF_MAX);
			end
		end
	endfunction

	always_comb begin
		next_cur = cur;
		w_slots = cur.slots;
		w_base = cur.base_slot;
		w_hop = cur.hop_us;

		// Slot payload and buffer for this node's role.
		slot_limit = cur.is_base ? cur.base_slot : cur.child_slot;
		cap = buf_cap(cur.is_base, cur.base_slot, cur.child_slot);
		need = cur.used + 8'(HDR_BYTES) + 8'(msg_req.len);

		// A message is taken only if it fits whole, is a protocol message,
		// arrives no later than the tx_start cycle of this hop, and stays within
		// the per-hop message limit.
		msg_ready = cur.tx_open
				&& msg_req.protocol
				&& msg_req.len <= slot_limit
				&& need <= cap
				&& cur.count < cur.mph;

		// A child keeps its slot while leased; a new child only gets one if
		// fewer slots are held than the slot count allows.
		reserved_count = ones(cur.reserved);
		child_grant = cur.is_base && child_req.valid
				&& (cur.reserved[child_req.id]
				|| 4'(reserved_count) < cur.slots);

		if (msg_req.valid && msg_ready) begin
			next_cur.used = need;
			next_cur.count = cur.count + 8'd1;
		end
		if (tx_start) begin
			next_cur.tx_open = 1'b0;
		end

		// Lease bookkeeping: the reservation survives gaps below the lease.
		if (hop_tick) begin
			for (int i = 0; i < 8; i++) begin
				if (cur.left[i] != 8'd0) begin
					next_cur.left[i] = cur.left[i] - 8'd1;
				end
				if (cur.left[i] <= 8'd1) begin
					next_cur.reserved[i] = 1'b0;
				end
			end
		end
		if (child_grant && child_req.valid) begin
			next_cur.reserved[child_req.id] = 1'b1;
			next_cur.left[child_req.id] = cur.lease;
		end

		// New hop: buffers empty and admission reopens.
		if (hop_tick) begin
			next_cur.used = 8'd0;
			next_cur.count = 8'd0;
			next_cur.tx_open = 1'b1;
		end

		// A remote follows the slot count heard from its base.
		if (!cur.is_base && beacon_valid) begin
			w_slots = slots_clamp(32'(beacon_slot_count));
		end

		if (reg_req.we) begin
			case (reg_req.addr)
				OFS_BASE_SLOT: begin
					w_base = base_clamp(reg_req.wdata, cur.slots);
				end
				OFS_SLOT_COUNT: begin
					if (cur.is_base) begin
						w_slots = slots_clamp(reg_req.wdata);
					end
				end
				OFS_HOP_DUR: begin
					w_hop = hop_round(reg_req.wdata[17:0]);
				end
				OFS_MSG_LIMIT: begin
					next_cur.mph = reg_req.wdata[7:0];
				end
				OFS_LEASE: begin
					next_cur.lease = reg_req.wdata[7:0];
				end
				OFS_NODE_MODE: begin
					next_cur.is_base = reg_req.wdata[0];
				end
				default: begin
				end
			endcase
		end

		// More slots shrink the base slot allowance, so the stored size
		// is pulled down whenever the slot count grows past it.
		next_cur.slots = w_slots;
		next_cur.base_slot = base_clamp(32'(w_base), w_slots);
		next_cur.hop_us = w_hop;
		next_cur.child_slot = solved_child;
		next_cur.dist_slots = w_slots;
		next_cur.buf_size = 7'(buf_cap(next_cur.is_base,
				next_cur.base_slot, next_cur.child_slot));

		next_cur.rdata = 32'h0000_0000;
		if (reg_req.re) begin
			case (reg_req.addr)
				OFS_BASE_SLOT: begin
					next_cur.rdata = 32'(cur.base_slot);
				end
				OFS_SLOT_COUNT: begin
					next_cur.rdata = 32'(cur.slots);
				end
				OFS_HOP_DUR: begin
					next_cur.rdata = 32'(cur.hop_us);
				end
				OFS_MSG_LIMIT: begin
					next_cur.rdata = 32'(cur.mph);
				end
				OFS_LEASE: begin
					next_cur.rdata = 32'(cur.lease);
				end
				OFS_NODE_MODE: begin
					next_cur.rdata = 32'(cur.is_base);
				end
				OFS_CHILD_SLOT: begin
					next_cur.rdata = 32'(cur.child_slot);
				end
				OFS_BUF_STAT: begin
					next_cur.rdata = {7'd0, cur.tx_open, cur.count,
							cur.used, 1'b0, cap[6:0]};
				end
				OFS_RESERVED: begin
					next_cur.rdata = 32'(cur.reserved);
				end
				OFS_REQ_HD: begin
					next_cur.rdata = 32'(hop_round(hop_formula(cur.slots,
							cur.base_slot, cur.child_slot)));
				end
				default: begin
					next_cur.rdata = 32'h0000_0000;
				end
			endcase
		end
	end

	always_ff @(posedge core_clk) begin
		if (sys_rst) begin
			cur <= '0;
			cur.base_slot <= RST_BASE_SLOT;
			cur.slots <= RST_SLOTS;
			cur.hop_us <= RST_HOP_US;
			cur.child_slot <= RST_CHILD_SLOT;
			cur.mph <= RST_MPH;
			cur.lease <= RST_LEASE;
			cur.tx_open <= 1'b1;
			cur.dist_slots <= RST_SLOTS;
			cur.buf_size <= RST_CHILD_SLOT + HDR_BYTES;
		end else begin
			cur <= next_cur;
		end
	end

	assign reg_rdata = cur.rdata;
	assign dist_slot_count = cur.dist_slots;
	assign child_slot_size = cur.child_slot;
	assign tx_buffer_size = cur.buf_size;

endmodule

// File: test/hop_sizing_properties.sv
// Checker for the hop slot sizing block, bound to its ports.
`timescale 1ns/1ps
module hop_sizing_properties
	import hop_sizing_pkg::*;
(
	input wire logic core_clk,
	input wire logic sys_rst,
	input wire reg_req_type reg_req,
	input wire logic [31:0] reg_rdata,
	input wire logic hop_tick,
	input wire logic tx_start,
	input wire msg_req_type msg_req,
	input wire logic msg_ready,
	input wire logic beacon_valid,
	input wire logic [3:0] beacon_slot_count,
	input wire logic [3:0] dist_slot_count,
	input wire child_req_type child_req,
	input wire logic child_grant,
	input wire logic [6:0] child_slot_size,
	input wire logic [6:0] tx_buffer_size
);
	default clocking @(posedge core_clk); endclocking
	default disable iff (sys_rst);
	a_child_max: assert property (child_slot_size <= CHILD_MAX)
		else $error("child slot size above its limit");
	a_buf_max: assert property (tx_buffer_size <= CHILD_BUF_MAX)
		else $error("transmit buffer above its limit");
	a_slot_range: assert property (dist_slot_count >= SLOTS_MIN
		&& dist_slot_count <= SLOTS_MAX)
		else $error("slot count out of range");
	a_fit_room: assert property (msg_ready |->
		8'(msg_req.len) + 8'd9 <= 8'(tx_buffer_size))
		else $error("message taken beyond buffer room");
	a_fit_slot: assert property (msg_ready |-> msg_req.len <= CHILD_MAX)
		else $error("message longer than any slot taken");
	a_proto_only: assert property (msg_ready |-> msg_req.protocol)
		else $error("non-protocol message taken");
	a_closed_hop: assert property (tx_start && !hop_tick ##1 !hop_tick
		|=> !msg_ready) else $error("admission open after start");
	a_grant_req: assert property (child_grant |-> child_req.valid)
		else $error("grant without a request");
	a_child_cause: assert property ($changed(child_slot_size) |->
		$past(reg_req.we) || $past(reg_req.we, 2) || $past(beacon_valid)
		|| $past(beacon_valid, 2)) else $error("child size moved by itself");
	a_rdata_zero: assert property (!$past(reg_req.re) |-> reg_rdata == 0)
		else $error("read data outside the answer cycle");
	c_msg_taken: cover property (msg_req.valid && msg_ready);
	c_grant: cover property (child_grant);
	c_beacon: cover property (beacon_valid);
endmodule
bind hop_slot_sizing hop_sizing_properties u_props (.core_clk(core_clk),
	.sys_rst(sys_rst), .reg_req(reg_req), .reg_rdata(reg_rdata),
	.hop_tick(hop_tick), .tx_start(tx_start), .msg_req(msg_req),
	.msg_ready(msg_ready), .beacon_valid(beacon_valid),
	.beacon_slot_count(beacon_slot_count), .dist_slot_count(dist_slot_count),
	.child_req(child_req), .child_grant(child_grant),
	.child_slot_size(child_slot_size), .tx_buffer_size(tx_buffer_size));

// File: test/peer_radio_model.sv
// Peer radios: a base that sends beacons and children that ask for slots.
`timescale 1ns/1ps
module peer_radio_model
	import hop_sizing_pkg::*;
(
	input wire logic core_clk,
	input wire logic child_grant,
	output logic beacon_valid,
	output logic [3:0] beacon_slot_count,
	output child_req_type child_req
);
	initial begin
		beacon_valid = 1'b0;
		beacon_slot_count = 4'h0;
		child_req = '0;
	end
	task automatic beacon(input logic [3:0] ns);
		@(posedge core_clk);
		beacon_valid <= 1'b1;
		beacon_slot_count <= ns;
		@(posedge core_clk);
		beacon_valid <= 1'b0;
		// A stale count left on the lines would hide a missing qualifier.
		beacon_slot_count <= ~ns;
	endtask
	task automatic ask(input logic [2:0] id, output logic g);
		@(posedge core_clk);
		child_req <= '{valid: 1'b1, id: id};
		#1 g = child_grant;
		@(posedge core_clk);
		child_req <= '{valid: 1'b0, id: ~id};
	endtask
endmodule

// File: test/testbench.sv
// Self-checking bench for the hop slot sizing block.
`timescale 1ns/1ps
module testbench;
	import hop_sizing_pkg::*;
	logic core_clk = 1'b0;
	logic sys_rst = 1'b1;
	reg_req_type reg_req = '0;
	msg_req_type msg_req = '0;
	logic hop_tick = 1'b0;
	logic tx_start = 1'b0;
	logic [31:0] reg_rdata;
	logic msg_ready, beacon_valid, child_grant, g;
	logic [3:0] beacon_slot_count, dist_slot_count;
	logic [6:0] child_slot_size, tx_buffer_size;
	child_req_type child_req;
	int errors = 0;
	int tests_run = 0;
	int c;
	int cw[3][3] = '{'{4, 96, 55600}, '{9, 110, 60000}, '{0, 110, 20000}};
	int ce[3][3] = '{'{4, 96, 56000}, '{8, 84, 60000}, '{1, 105, 20000}};
	always #5 core_clk = ~core_clk;
	hop_slot_sizing DUT (.core_clk(core_clk), .sys_rst(sys_rst),
		.reg_req(reg_req), .reg_rdata(reg_rdata), .hop_tick(hop_tick),
		.tx_start(tx_start), .msg_req(msg_req), .msg_ready(msg_ready),
		.beacon_valid(beacon_valid), .beacon_slot_count(beacon_slot_count),
		.dist_slot_count(dist_slot_count), .child_req(child_req),
		.child_grant(child_grant), .child_slot_size(child_slot_size),
		.tx_buffer_size(tx_buffer_size));
	peer_radio_model peer (.core_clk(core_clk), .child_grant(child_grant),
		.beacon_valid(beacon_valid), .beacon_slot_count(beacon_slot_count),
		.child_req(child_req));
	task automatic check(input logic [31:0] got, input logic [31:0] exp);
		tests_run++;
		if (got !== exp) begin
			errors++;
			$display("FAIL %0t got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		@(posedge core_clk);
		reg_req <= '{addr: a, wdata: d, we: 1'b1, re: 1'b0};
		@(posedge core_clk);
		reg_req.we <= 1'b0;
	endtask
	task automatic rd(input logic [7:0] a, input logic [31:0] e);
		@(posedge core_clk);
		reg_req <= '{addr: a, wdata: 32'h0, we: 1'b0, re: 1'b1};
		@(posedge core_clk);
		reg_req.re <= 1'b0;
		#1 check(reg_rdata, e);
	endtask
	task automatic offer(input logic [6:0] n, input logic p, input logic e);
		@(posedge core_clk);
		msg_req <= '{valid: 1'b1, protocol: p, len: n};
		#1 check(32'(msg_ready), 32'(e));
		@(posedge core_clk);
		msg_req.valid <= 1'b0;
	endtask
	task automatic pulse(input logic hop);
		@(posedge core_clk);
		{hop_tick, tx_start} <= {hop, !hop};
		@(posedge core_clk);
		{hop_tick, tx_start} <= 2'b00;
	endtask
	task automatic grant(input logic [2:0] id, input logic e);
		peer.ask(id, g);
		check(32'(g), 32'(e));
	endtask
	// Floor solution of the hop relation; negative room gives no slot.
	function automatic int exp_child(int slots, int base, int dur);
		int t;
		t = dur - 80 * base - 3280;
		t = (t < 0) ? -1 : t / slots - 2440;
		t = (t < 0) ? 0 : t / 80;
		return (t > 109) ? 109 : t;
	endfunction
	function automatic int exp_hop(int slots, int base, int child);
		int t;
		t = slots * (80 * child + 2440) + 80 * base + 3280;
		return (t + 499) / 500 * 500;
	endfunction
	task automatic summarize;
		$display("Comparisons %0d, mismatches %0d", tests_run, errors);
		if (errors == 0 && tests_run > 0) begin
			$display("STATUS OK");
		end else begin
			$display("STATUS NOT OK");
		end
		$finish;
	endtask
	initial begin
		#200000;
		errors++;
		summarize;
	end
	initial begin
		repeat (6) @(posedge core_clk);
		sys_rst <= 1'b0;
		rd(OFS_BASE_SLOT, 32'h28);
		rd(OFS_SLOT_COUNT, 32'h3);
		rd(OFS_HOP_DUR, 32'h4E20);
		rd(OFS_MSG_LIMIT, 32'h8);
		rd(OFS_CHILD_SLOT, 32'h19);
		rd(8'h30, 32'h0);
		check(32'(tx_buffer_size), 32'h22);
		check(32'(dist_slot_count), 32'h3);
		wr(OFS_NODE_MODE, 32'h1);
		for (int i = 0; i < 3; i++) begin
			wr(OFS_SLOT_COUNT, 32'(cw[i][0]));
			wr(OFS_BASE_SLOT, 32'(cw[i][1]));
			wr(OFS_HOP_DUR, 32'(cw[i][2]));
			c = exp_child(ce[i][0], ce[i][1], ce[i][2]);
			rd(OFS_SLOT_COUNT, 32'(ce[i][0]));
			rd(OFS_BASE_SLOT, 32'(ce[i][1]));
			rd(OFS_HOP_DUR, 32'(ce[i][2]));
			rd(OFS_CHILD_SLOT, 32'(c));
			check(32'(child_slot_size), 32'(c));
			rd(OFS_REQ_HD, 32'(exp_hop(ce[i][0], ce[i][1], c)));
			check(32'(tx_buffer_size), 32'(ce[i][1] + 9));
		end
		wr(OFS_BASE_SLOT, 32'h14);
		// A transmit data message with length byte 24 needs 21 slot bytes.
		offer(7'(24 - 3), 1'b1, 1'b0);
		offer(7'd5, 1'b0, 1'b0);
		offer(7'd10, 1'b1, 1'b1);
		offer(7'd11, 1'b1, 1'b0);
		offer(7'd1, 1'b1, 1'b1);
		rd(OFS_BUF_STAT, 32'h0102_1D1D);
		pulse(1'b1);
		wr(OFS_MSG_LIMIT, 32'h1);
		offer(7'd1, 1'b1, 1'b1);
		offer(7'd1, 1'b1, 1'b0);
		pulse(1'b1);
		pulse(1'b0);
		offer(7'd1, 1'b1, 1'b0);
		pulse(1'b1);
		offer(7'd1, 1'b1, 1'b1);
		wr(OFS_SLOT_COUNT, 32'h2);
		wr(OFS_LEASE, 32'h2);
		rd(OFS_LEASE, 32'h2);
		rd(OFS_NODE_MODE, 32'h1);
		grant(3'd0, 1'b1);
		grant(3'd1, 1'b1);
		grant(3'd2, 1'b0);
		grant(3'd0, 1'b1);
		rd(OFS_RESERVED, 32'h3);
		pulse(1'b1);
		grant(3'd2, 1'b0);
		pulse(1'b1);
		grant(3'd2, 1'b1);
		rd(OFS_RESERVED, 32'h4);
		wr(OFS_NODE_MODE, 32'h0);
		peer.beacon(4'd5);
		#1 check(32'(dist_slot_count), 32'h5);
		peer.beacon(4'hC);
		#1 check(32'(dist_slot_count), 32'h8);
		wr(OFS_SLOT_COUNT, 32'h6);
		rd(OFS_SLOT_COUNT, 32'h8);
		summarize;
	end
endmodule
